// ---- hdl/sdlst_regs.svh ----
// Register indices, field positions, reset values and counts of the line-state tracker
`ifndef SDLST_REGS_SVH
`define SDLST_REGS_SVH
`define SDLST_IDX_CMD 8'h0f
`define SDLST_IDX_STATE 8'h24
`define SDLST_IDX_GAP 8'h28
`define SDLST_IDX_EVT 8'h30
`define SDLST_B_CMD_DAT 0
`define SDLST_B_CMD_RD 1
`define SDLST_B_CMD_BSY 2
`define SDLST_CMD_CNT_LSB 16
`define SDLST_B_HALT 0
`define SDLST_B_CONT 1
`define SDLST_B_CMD_INH 0
`define SDLST_B_DAT_INH 1
`define SDLST_B_DAT_BUSY 2
`define SDLST_B_WR_ACT 8
`define SDLST_B_RD_ACT 9
`define SDLST_RST_CMD 32'h0000_0000
`define SDLST_RST_FLAGS 1'b0
`define SDLST_NOBUSY_SDCLK 8
`endif

// ---- hdl/sdlst_pkg.sv ----
// Types of the line-state tracker
package sdlst_pkg;
   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_RD     = 6'h02,
      ST_RDWAIT = 6'h04,
      ST_WR     = 6'h08,
      ST_BUSY   = 6'h10,
      ST_WRGAP  = 6'h20
   } sdlst_state_type;

   typedef struct packed {
      logic gap;
      logic xfer;
      logic cmd;
   } sdlst_evt_type;
endpackage

// ---- hdl/sdlst_core.sv ----
// SD host present-state flags and their completion events
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "sdlst_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Write-active sets after the write command end bit.
// - Write-active clears after CRC status of the last programmed block.
// - With halt pending, write-active clears after that block's CRC status.
// - Write-active falling on a halt raises a block gap event.
// - Status bit 2 shows DAT lines in use; bits 7:3 read zero.
// - Status bit 1 is DAT-lines-busy OR read-active.
// - Fall of the DAT inhibit raises transfer complete.
// - Busy-response commands hold the DAT inhibit until busy ends.
// - CMD inhibit sets on command write, clears on response.
// - Fall of the CMD inhibit raises command complete.
// - Conflict or auto-stop error keeps CMD inhibit, no command complete.
// - CMD-only commands are accepted whenever CMD inhibit is clear.
// - Read DAT-busy falling between blocks raises block gap.
// - Read DAT-busy sets at command end or on continue.
// - Read DAT-busy clears at end bit of last block.
// - Read DAT-busy clears when a halt read-wait begins.
// - Halt drives read wait at block end; buffer full keeps it.
// - Write DAT-busy sets at command end or on continue.
// - Write DAT-busy clears on busy release; no busy in 8 clocks means free.
// - Write DAT-busy clears on busy release before a halt pause.
// - Write DAT-busy falling raises transfer complete.
// - Read-active falls when all blocks, or in a halt read wait the buffered ones, reach the system; raises transfer complete.
module sdlst_core import sdlst_pkg::*; #(
   parameter int BLK_W = 16,
   parameter int NB_CLKS = `SDLST_NOBUSY_SDCLK
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [9:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_sd_clk,
   input wire logic i_sd_dat0,
   input wire logic i_cmd_end,
   input wire logic i_rsp_done,
   input wire logic i_cmd_conflict,
   input wire logic i_acmd12_err,
   input wire logic i_rd_blk_end,
   input wire logic i_wr_crc_done,
   input wire logic i_blk_to_sys,
   input wire logic i_buf_full,
   output logic o_dat2_o,
   output logic o_dat2_oe,
   output sdlst_evt_type o_evt
);

   if (BLK_W < 1 || BLK_W > 16) begin : g_chk_blk
      $error("BLK_W must be 1 to 16");
   end
   if (NB_CLKS < 1 || NB_CLKS > 15) begin : g_chk_nb
      $error("NB_CLKS must be 1 to 15");
   end

   localparam logic [3:0] NB_MAX = 4'(NB_CLKS);
   localparam logic [BLK_W-1:0] ONE = BLK_W'(1);

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode

   logic hit_cmd;
   logic hit_state;
   logic hit_gap;
   logic hit_evt;
   logic cmd_wr;
   logic cont_wr;
   assign hit_cmd = i_addr == {`SDLST_IDX_CMD, 2'b00};
   assign hit_state = i_addr == {`SDLST_IDX_STATE, 2'b00};
   assign hit_gap = i_addr == {`SDLST_IDX_GAP, 2'b00};
   assign hit_evt = i_addr == {`SDLST_IDX_EVT, 2'b00};
   assign cmd_wr = i_wr & hit_cmd;
   assign cont_wr = i_wr & hit_gap & i_wdata[`SDLST_B_CONT];

   logic [31:0] cmd_q;
   logic halt_q;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cmd_q <= `SDLST_RST_CMD;
         halt_q <= 1'b0;
      end else begin
         if (cmd_wr) begin
            cmd_q <= i_wdata;
         end
         if (i_wr && hit_gap) begin
            halt_q <= i_wdata[`SDLST_B_HALT];
         end
      end
   end

   logic cmd_dat;
   logic cmd_rd;
   logic cmd_bsy;
   assign cmd_dat = cmd_q[`SDLST_B_CMD_DAT];
   assign cmd_rd = cmd_q[`SDLST_B_CMD_RD];
   assign cmd_bsy = cmd_q[`SDLST_B_CMD_BSY];

   ////////////////////////////////////////////////////////////////////////////////
   // SD clock and DAT0 sampling

   logic [2:0] clk_s_q;
   logic [2:0] d0_s_q;
   logic clk_f_q;
   logic clk_prev_q;
   logic d0_f_q;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         clk_s_q <= 3'h0;
         d0_s_q <= 3'h7;
         clk_f_q <= 1'b0;
         clk_prev_q <= 1'b0;
         d0_f_q <= 1'b1;
      end else begin
         clk_s_q <= {clk_s_q[1:0], i_sd_clk};
         d0_s_q <= {d0_s_q[1:0], i_sd_dat0};
         if (clk_s_q[1] == clk_s_q[2]) begin
            clk_f_q <= clk_s_q[2];
         end
         if (d0_s_q[1] == d0_s_q[2]) begin
            d0_f_q <= d0_s_q[2];
         end
         clk_prev_q <= clk_f_q;
      end
   end

   logic sd_edge;
   assign sd_edge = clk_f_q & ~clk_prev_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Transfer sequencing

   sdlst_state_type st_q;
   logic [BLK_W-1:0] blk_left_q;
   logic last;
   logic rel;
   logic gap_stop_q;
   logic st_idle;
   logic st_rd;
   logic st_rdwait;
   logic st_wr;
   logic st_busy;
   logic st_wrgap;
   assign st_idle = st_q == ST_IDLE;
   assign st_rd = st_q == ST_RD;
   assign st_rdwait = st_q == ST_RDWAIT;
   assign st_wr = st_q == ST_WR;
   assign st_busy = st_q == ST_BUSY;
   assign st_wrgap = st_q == ST_WRGAP;
   assign last = blk_left_q <= ONE;

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q <= ST_IDLE;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (i_cmd_end && cmd_dat) begin
                  st_q <= cmd_rd ? ST_RD : ST_WR;
               end else if (i_cmd_end && cmd_bsy) begin
                  st_q <= ST_BUSY;
               end
            end
            ST_RD: begin
               if (i_rd_blk_end && last) begin
                  st_q <= ST_IDLE;
               end else if (i_rd_blk_end && halt_q) begin
                  st_q <= ST_RDWAIT;
               end
            end
            ST_RDWAIT: begin
               if (cont_wr) begin
                  st_q <= ST_RD;
               end
            end
            ST_WR: begin
               if (i_wr_crc_done && (last || halt_q)) begin
                  st_q <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (rel) begin
                  st_q <= gap_stop_q ? ST_WRGAP : ST_IDLE;
               end
            end
            ST_WRGAP: begin
               if (cont_wr) begin
                  st_q <= ST_WR;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         blk_left_q <= '0;
         gap_stop_q <= 1'b0;
      end else begin
         if (cmd_wr && i_wdata[`SDLST_B_CMD_DAT]) begin
            blk_left_q <= i_wdata[`SDLST_CMD_CNT_LSB +: BLK_W] == '0 ? ONE : i_wdata[`SDLST_CMD_CNT_LSB +: BLK_W];
         end else if ((st_rd && i_rd_blk_end) || (st_wr && i_wr_crc_done)) begin
            blk_left_q <= blk_left_q - ONE;
         end
         if (st_idle) begin
            gap_stop_q <= 1'b0;
         end else if (st_wr && i_wr_crc_done) begin
            gap_stop_q <= !last && halt_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Card write busy, released or never seen

   logic seen_q;
   logic [3:0] nb_q;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         seen_q <= 1'b0;
         nb_q <= 4'h0;
      end else if (!st_busy) begin
         seen_q <= 1'b0;
         nb_q <= 4'h0;
      end else begin
         if (!d0_f_q) begin
            seen_q <= 1'b1;
         end
         if (sd_edge && nb_q != NB_MAX) begin
            nb_q <= nb_q + 4'h1;
         end
      end
   end
   assign rel = st_busy & ((seen_q & d0_f_q) | (~seen_q & d0_f_q & (nb_q == NB_MAX)));

   ////////////////////////////////////////////////////////////////////////////////
   // Read blocks held in the buffer

   logic [BLK_W-1:0] sys_left_q;
   logic [BLK_W-1:0] pend_q;
   logic rx_blk;
   assign rx_blk = st_rd & i_rd_blk_end;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sys_left_q <= '0;
         pend_q <= '0;
      end else begin
         if (cmd_wr && i_wdata[`SDLST_B_CMD_DAT]) begin
            sys_left_q <= i_wdata[`SDLST_CMD_CNT_LSB +: BLK_W];
            pend_q <= '0;
         end else begin
            if (i_blk_to_sys && sys_left_q != '0) begin
               sys_left_q <= sys_left_q - ONE;
            end
            pend_q <= pend_q + BLK_W'(rx_blk) - BLK_W'(i_blk_to_sys && pend_q != '0);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Present-state flags

   logic cmd_inh_q;
   logic cmd_inh_d;
   logic busy_q;
   logic busy_d;
   logic wr_act_q;
   logic wr_act_d;
   logic rd_act_q;
   logic rd_act_d;
   logic dat_inh;
   assign dat_inh = busy_q | rd_act_q;

   always_comb begin
      cmd_inh_d = cmd_inh_q;
      if (i_rsp_done && !i_cmd_conflict && !i_acmd12_err) begin
         cmd_inh_d = 1'b0;
      end
      if (cmd_wr || (cmd_inh_q && (i_cmd_conflict || i_acmd12_err))) begin
         cmd_inh_d = 1'b1;
      end
      wr_act_d = wr_act_q;
      if (st_wr && i_wr_crc_done && (last || halt_q)) begin
         wr_act_d = 1'b0;
      end
      if ((st_idle && i_cmd_end && cmd_dat && !cmd_rd) || (st_wrgap && cont_wr)) begin
         wr_act_d = 1'b1;
      end
      busy_d = busy_q;
      if ((rx_blk && (last || halt_q)) || rel) begin
         busy_d = 1'b0;
      end
      if ((st_idle && i_cmd_end && (cmd_dat || cmd_bsy)) || ((st_rdwait || st_wrgap) && cont_wr)) begin
         busy_d = 1'b1;
      end
      rd_act_d = rd_act_q;
      if (rd_act_q && i_blk_to_sys && (sys_left_q <= ONE || (st_rdwait && pend_q == ONE))) begin
         rd_act_d = 1'b0;
      end
      if ((st_idle && i_cmd_end && cmd_dat && cmd_rd) || (st_rdwait && cont_wr)) begin
         rd_act_d = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cmd_inh_q <= `SDLST_RST_FLAGS;
         busy_q <= `SDLST_RST_FLAGS;
         wr_act_q <= `SDLST_RST_FLAGS;
         rd_act_q <= `SDLST_RST_FLAGS;
      end else begin
         cmd_inh_q <= cmd_inh_d;
         busy_q <= busy_d;
         wr_act_q <= wr_act_d;
         rd_act_q <= rd_act_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Events and read wait

   sdlst_evt_type evt_set;
   sdlst_evt_type evt_st_q;
   logic rd_halt;
   assign rd_halt = rx_blk & halt_q & ~last;
   assign evt_set.cmd = cmd_inh_q & ~cmd_inh_d;
   assign evt_set.xfer = (dat_inh & ~(busy_d | rd_act_d)) | (rd_act_q & ~rd_act_d);
   assign evt_set.gap = (wr_act_q & ~wr_act_d & ~last) | rd_halt;

   logic rw_q;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_evt <= '0;
         evt_st_q <= '0;
         rw_q <= 1'b0;
      end else begin
         o_evt <= evt_set;
         if (i_wr && hit_evt) begin
            evt_st_q <= (evt_st_q & ~sdlst_evt_type'(i_wdata[2:0])) | evt_set;
         end else begin
            evt_st_q <= evt_st_q | evt_set;
         end
         rw_q <= rd_halt | (st_rdwait & ~cont_wr) | (st_rd & i_buf_full);
      end
   end
   assign o_dat2_o = 1'b0;
   assign o_dat2_oe = rw_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Read port

   logic [31:0] stat;
   always_comb begin
      stat = 32'h0;
      stat[`SDLST_B_CMD_INH] = cmd_inh_q;
      stat[`SDLST_B_DAT_INH] = dat_inh;
      stat[`SDLST_B_DAT_BUSY] = busy_q;
      stat[`SDLST_B_WR_ACT] = wr_act_q;
      stat[`SDLST_B_RD_ACT] = rd_act_q;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= 32'h0;
      end else if (!i_rd) begin
         o_rdata <= 32'h0;
      end else if (hit_state) begin
         o_rdata <= stat;
      end else if (hit_cmd) begin
         o_rdata <= cmd_q;
      end else if (hit_gap) begin
         o_rdata <= {31'h0, halt_q};
      end else if (hit_evt) begin
         o_rdata <= {29'h0, evt_st_q};
      end else begin
         o_rdata <= 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   property p_cmd_set;
      cmd_wr |=> cmd_inh_q;
   endproperty
   a_cmd_set: assert property (p_cmd_set) else $error("CMD inhibit not set on command write");

   property p_cmd_done;
      $fell(cmd_inh_q) |-> o_evt.cmd && evt_st_q.cmd;
   endproperty
   a_cmd_done: assert property (p_cmd_done) else $error("No command complete on CMD inhibit fall");

   property p_conflict;
      cmd_inh_q && (i_cmd_conflict || i_acmd12_err) |=> cmd_inh_q && !o_evt.cmd;
   endproperty
   a_conflict: assert property (p_conflict) else $error("CMD inhibit dropped on conflict");

   property p_stat_read;
      i_rd && hit_state |=> o_rdata[1] == (o_rdata[2] | o_rdata[9]) && o_rdata[7:3] == 5'h0;
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("Status read inconsistent");

   property p_xfer_done;
      $fell(busy_q | rd_act_q) |-> o_evt.xfer;
   endproperty
   a_xfer_done: assert property (p_xfer_done) else $error("No transfer complete on DAT inhibit fall");

   property p_wr_start;
      st_idle && i_cmd_end && cmd_dat && !cmd_rd |=> wr_act_q && busy_q && st_wr;
   endproperty
   a_wr_start: assert property (p_wr_start) else $error("Write flags not set at command end");

   property p_wr_last;
      st_wr && i_wr_crc_done && last |=> !wr_act_q && busy_q ##1 st_busy;
   endproperty
   a_wr_last: assert property (p_wr_last) else $error("Write-active kept after last CRC status");

   property p_wr_gap;
      st_wr && i_wr_crc_done && !last && halt_q |=> !wr_act_q && o_evt.gap;
   endproperty
   a_wr_gap: assert property (p_wr_gap) else $error("No block gap on write halt");

   property p_no_busy;
      st_busy && !seen_q && d0_f_q && nb_q == NB_MAX |=> !busy_q;
   endproperty
   a_no_busy: assert property (p_no_busy) else $error("DAT busy held with no card busy");

   property p_rd_halt;
      rd_halt |=> o_dat2_oe && !busy_q && o_evt.gap && st_rdwait;
   endproperty
   a_rd_halt: assert property (p_rd_halt) else $error("Read halt not handled at block gap");

   property p_rd_last;
      rx_blk && last |=> !busy_q && st_idle;
   endproperty
   a_rd_last: assert property (p_rd_last) else $error("DAT busy kept after last read block");

   c_rd_done: cover property (st_rd ##1 st_idle ##[1:50] $fell(rd_act_q));
   c_wr_gap: cover property (st_busy ##1 st_wrgap);
   c_r1b: cover property (st_idle && i_cmd_end && !cmd_dat && cmd_bsy);
   c_conflict: cover property (cmd_inh_q && i_cmd_conflict);

endmodule

// ---- testbench/sdlst_card.sv ----
// SD card model: SD clock within frames and write busy on DAT0
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module sdlst_card (
   input wire logic i_clk_en,
   input wire logic i_busy_go,
   input wire logic [3:0] i_busy_len,
   output logic o_sd_clk,
   output logic o_sd_dat0
);
   // SD clock, 32 ns period, still outside frames
   initial begin
      o_sd_clk = 1'b0;
      forever begin
         #16;
         o_sd_clk = i_clk_en ? ~o_sd_clk : 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // DAT0 pulled up; busy low for a set count of SD clocks, none if zero
   initial begin
      o_sd_dat0 = 1'b1;
      forever begin
         @(posedge i_busy_go);
         if (i_busy_len != 4'h0) begin
            o_sd_dat0 = 1'b0;
            repeat (i_busy_len) @(posedge o_sd_clk);
            o_sd_dat0 = 1'b1;
         end
      end
   end
endmodule

// ---- testbench/tb_top.sv ----
// Testbench of the line-state tracker
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
   import sdlst_pkg::*;
   localparam logic [9:0] A_CMD = 10'h03c;
   localparam logic [9:0] A_ST = 10'h090;
   localparam logic [9:0] A_GAP = 10'h0a0;
   localparam logic [9:0] A_EVT = 10'h0c0;
   logic i_core_clk, i_nrst, i_wr, i_rd, conflict, a12err, buf_full, sd_en, busy_go, clr, sd_clk, dat0, dat2_o, dat2_oe;
   logic [9:0] i_addr;
   logic [31:0] i_wdata, o_rdata, rdv;
   logic [4:0] eng;
   logic [3:0] busy_len;
   logic [2:0] seen;
   sdlst_evt_type evt;
   int errors, n_tests;

   sdlst_core #(.BLK_W(4), .NB_CLKS(2)) sdlst_core_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sd_clk(sd_clk),
      .i_sd_dat0(dat0), .i_cmd_end(eng[0]), .i_rsp_done(eng[1]), .i_cmd_conflict(conflict),
      .i_acmd12_err(a12err), .i_rd_blk_end(eng[2]), .i_wr_crc_done(eng[3]), .i_blk_to_sys(eng[4]),
      .i_buf_full(buf_full), .o_dat2_o(dat2_o), .o_dat2_oe(dat2_oe), .o_evt(evt));
   sdlst_card sdlst_card_i (.i_clk_en(sd_en), .i_busy_go(busy_go), .i_busy_len(busy_len),
      .o_sd_clk(sd_clk), .o_sd_dat0(dat0));

   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) seen <= clr ? 3'h0 : (seen | evt);
   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] st(input logic c, d, b, w, r);
      st = {22'h0, r, w, 5'h0, b, d, c};
   endfunction
   task chk(input logic [31:0] got, exp, input string m);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [9:0] a);
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      @(negedge i_core_clk);
      rdv = o_rdata;
      @(posedge i_core_clk);
   endtask
   task pulse(input int k);
      @(posedge i_core_clk);
      eng[k] <= 1'b1;
      @(posedge i_core_clk);
      eng[k] <= 1'b0;
   endtask
   task go_busy(input logic [3:0] n);
      @(posedge i_core_clk);
      busy_len <= n;
      busy_go <= 1'b1;
      @(posedge i_core_clk);
      busy_go <= 1'b0;
   endtask
   task chk_st(input logic [31:0] e, input string m);
      rd(A_ST);
      chk(rdv, e, m);
   endtask
   task clr_ev;
      @(posedge i_core_clk);
      clr <= 1'b1;
      @(posedge i_core_clk);
      clr <= 1'b0;
   endtask
   task chk_ev(input logic [2:0] e, input string m);
      repeat (2) @(posedge i_core_clk);
      chk({29'h0, seen}, {29'h0, e}, m);
      clr_ev();
   endtask
   task wait_ev(input int idx, input string m);
      int i;
      i = 0;
      while (seen[idx] !== 1'b1 && i < 400) begin
         @(posedge i_core_clk);
         i++;
      end
      chk({31'h0, seen[idx]}, 32'h1, m);
      clr_ev();
   endtask
   task rst;
      i_nrst <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      i_nrst <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_reset;
      chk_st(32'h0, "status after reset");
      wr(A_ST, 32'hffff_ffff);
      chk_st(32'h0, "status write ignored");
      rd(10'h3fc);
      chk(rdv, 32'h0, "unmapped read");
   endtask
   task t_cmd_only;
      sd_en <= 1'b0;
      wr(A_CMD, 32'h0);
      chk_st(st(1, 0, 0, 0, 0), "cmd inhibit set");
      pulse(1);
      chk_ev(3'b001, "cmd complete");
      chk_st(32'h0, "cmd inhibit clear");
      rd(A_EVT);
      chk(rdv, 32'h1, "sticky cmd event");
      wr(A_EVT, 32'h7);
      rd(A_EVT);
      chk(rdv, 32'h0, "event cleared");
      sd_en <= 1'b1;
   endtask
   task t_write;
      wr(A_CMD, 32'h0002_0001);
      pulse(0);
      chk_st(st(1, 1, 1, 1, 0), "write start");
      pulse(1);
      chk_ev(3'b001, "write cmd complete");
      chk_st(st(0, 1, 1, 1, 0), "cmd free, dat held");
      wr(A_CMD, 32'h0);
      chk_st(st(1, 1, 1, 1, 0), "abort-type cmd taken while dat busy");
      pulse(1);
      chk_ev(3'b001, "abort-type cmd complete");
      pulse(3);
      chk_st(st(0, 1, 1, 1, 0), "one block left");
      go_busy(4'h6);
      pulse(3);
      chk_st(st(0, 1, 1, 0, 0), "write active off, busy");
      wait_ev(1, "busy release xfer");
      chk_st(32'h0, "write idle");
   endtask
   task t_nobusy;
      wr(A_CMD, 32'h0001_0001);
      pulse(0);
      pulse(1);
      chk_ev(3'b001, "cmd complete");
      pulse(3);
      chk_st(st(0, 1, 1, 0, 0), "waiting for busy");
      wait_ev(1, "no busy timeout");
      chk_st(32'h0, "idle after no busy");
   endtask
   task t_wr_halt;
      wr(A_GAP, 32'h1);
      wr(A_CMD, 32'h0003_0001);
      pulse(0);
      pulse(1);
      chk_ev(3'b001, "cmd complete");
      go_busy(4'h4);
      pulse(3);
      chk_ev(3'b100, "write gap event");
      chk_st(st(0, 1, 1, 0, 0), "halt write active off");
      wait_ev(1, "halt busy release");
      chk_st(32'h0, "paused idle");
      rd(A_CMD);
      chk(rdv, 32'h0003_0001, "command saved at pause");
      wr(A_GAP, 32'h0);
      wr(A_GAP, 32'h2);
      rd(A_ST);
      chk(rdv & 32'h4, 32'h4, "continue write busy");
      pulse(3);
      go_busy(4'h3);
      pulse(3);
      wait_ev(1, "resumed write done");
      chk_st(32'h0, "write idle");
   endtask
   task t_read;
      wr(A_GAP, 32'h1);
      wr(A_CMD, 32'h0004_0003);
      pulse(0);
      pulse(1);
      chk_ev(3'b001, "cmd complete");
      chk_st(st(0, 1, 1, 0, 1), "read start");
      pulse(2);
      chk_ev(3'b100, "read gap event");
      chk({31'h0, dat2_oe}, 32'h1, "read wait on");
      chk({31'h0, dat2_o}, 32'h0, "read wait low");
      chk_st(st(0, 1, 0, 0, 1), "read wait pause");
      wr(A_GAP, 32'h0);
      wr(A_GAP, 32'h2);
      chk_st(st(0, 1, 1, 0, 1), "read continue");
      chk({31'h0, dat2_oe}, 32'h0, "read wait off");
      buf_full <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      chk({31'h0, dat2_oe}, 32'h1, "buffer full read wait");
      buf_full <= 1'b0;
      repeat (3) pulse(2);
      chk_ev(3'b000, "last block no gap");
      chk_st(st(0, 1, 0, 0, 1), "last block end");
      repeat (4) pulse(4);
      chk_ev(3'b010, "read xfer complete");
      chk_st(32'h0, "read idle");
   endtask
   task t_busy_rsp;
      wr(A_CMD, 32'h0000_0004);
      pulse(0);
      go_busy(4'h4);
      pulse(1);
      chk_ev(3'b001, "cmd complete");
      rd(A_ST);
      chk(rdv & 32'h3, 32'h2, "busy response holds dat");
      wait_ev(1, "busy response done");
      chk_st(32'h0, "idle");
   endtask
   task t_conflict(input int e);
      wr(A_CMD, 32'h0);
      if (e == 0) conflict <= 1'b1;
      else a12err <= 1'b1;
      pulse(1);
      chk_ev(3'b000, "no cmd complete on error");
      chk_st(st(1, 0, 0, 0, 0), "inhibit held on error");
      conflict <= 1'b0;
      a12err <= 1'b0;
      rst();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict
   task results;
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      results();
   end
   initial begin
      i_nrst = 1'b0;
      {i_wr, i_rd, conflict, a12err, buf_full, busy_go, clr} = 7'h0;
      sd_en = 1'b1;
      i_addr = 10'h0;
      i_wdata = 32'h0;
      eng = 5'h0;
      busy_len = 4'h0;
      rst();
      clr_ev();
      t_reset();
      t_cmd_only();
      t_write();
      t_nobusy();
      t_wr_halt();
      t_read();
      t_busy_rsp();
      t_conflict(0);
      t_conflict(1);
      t_reset();
      results();
   end
endmodule
